// ===== pkg/ncp_busy_if.sv
// Interface between the port decoder and the busy latch.
// All signals are on core_clk and already synchronised.
`timescale 1ns/1ps
interface ncp_busy_if;
	logic busy;
	logic error;
	logic clear;
	logic latched;
	modport ctl (output busy, output error, output clear, input latched);
	modport latch (input busy, input error, input clear, output latched);
endinterface : ncp_busy_if

// ===== pkg/ncp_pkg.sv
// Types shared by the coprocessor I/O port modules.
// Constants live in ncp_regs.svh; this package holds only types.
package ncp_pkg;
	typedef enum logic [1:0] {
		NCP_ACC_NONE,
		NCP_ACC_WRITE,
		NCP_ACC_READ
	} ncp_acc_t;

	typedef enum {
		NCP_RST_IDLE,
		NCP_RST_PULSE
	} ncp_rst_state_t;
endpackage : ncp_pkg

// ===== pkg/ncp_regs.svh
// Port addresses, field positions and timing for the coprocessor I/O port.
// Assumes a 10-bit I/O address from the host and a 100 MHz core clock.
`ifndef NCP_REGS_SVH
`define NCP_REGS_SVH

`define NCP_ADDR_W 10
`define NCP_BOARD_LO 10'h000
`define NCP_BOARD_HI 10'h0FF
`define NCP_CHAN_LO 10'h100
`define NCP_CHAN_HI 10'h3FF
`define NCP_BUSY_CLEAR 10'h0F0
`define NCP_RESET_TRIGGER 10'h0F1
`define NCP_DATA_PORT_A 10'h0F8
`define NCP_DATA_PORT_B 10'h0FA
`define NCP_DATA_PORT_C 10'h0FC
`define NCP_PORT_A_IDX 2'h0
`define NCP_PORT_B_IDX 2'h1
`define NCP_PORT_C_IDX 2'h2
`define NCP_DATA_RESET 8'h00
`define NCP_CLK_PERIOD_NS 10
`define NCP_RESET_PULSE_NS 200
`define NCP_SYNC_RESET 1'b1

`endif

// ===== verif/ncp_cp_model.sv
// Behavioural coprocessor on the far side of the port.
// Busy length and error are commanded by the bench per write.
`timescale 1ns/1ps
module ncp_cp_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cp_wr,
	input wire logic [1:0] cp_port,
	input wire logic [7:0] cp_wdata,
	input wire logic cp_reset,
	input wire logic err_req,
	input wire logic [3:0] busy_len,
	output logic [7:0] cp_rdata,
	output logic cp_busy_n,
	output logic cp_error_n
);
	logic [7:0] mem [0:3];
	logic [3:0] cnt;
	logic err;
	always @(posedge core_clk) begin
		if (rst || cp_reset) begin
			cnt <= 4'h0;
			err <= 1'b0;
		end else if (cp_wr) begin
			mem[cp_port] <= cp_wdata;
			cnt <= busy_len;
			err <= err_req;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	assign cp_busy_n = (cnt == 4'h0);
	assign cp_error_n = !(err && cnt != 4'h0);
	assign cp_rdata = mem[cp_port];
endmodule : ncp_cp_model

// ===== verif/ncp_io_port_assertions.sv
// Checker for the coprocessor I/O port, bound to its top module.
// Assumes the host holds the address while a strobe is low.
`timescale 1ns/1ps
`include "ncp_regs.svh"
module ncp_io_port_assertions #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] io_addr,
	input wire logic io_wr_n,
	input wire logic io_byte,
	input wire logic board_sel,
	input wire logic chan_sel,
	input wire logic cp_wr,
	input wire logic cp_busy_n,
	input wire logic cp_error_n,
	input wire logic cpu_busy_n,
	input wire logic cp_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_fault;
		!cp_error_n && !cp_busy_n;
	endsequence
	sequence s_quiet;
		io_wr_n [*8];
	endsequence
	// Anchored at the strobe's first cycle; an earlier fault may still set
	sequence s_clear;
		$past(io_wr_n) ##0 (io_addr == `NCP_BUSY_CLEAR && io_byte
			&& !io_wr_n && cp_busy_n && cp_error_n) [*3];
	endsequence
	property p_board;
		board_sel |-> $past(io_addr, 3) <= `NCP_BOARD_HI;
	endproperty
	property p_chan;
		chan_sel |-> $past(io_addr, 3) >= `NCP_CHAN_LO;
	endproperty
	property p_ports;
		cp_wr |-> board_sel && $past(io_addr, 3) inside
			{`NCP_DATA_PORT_A, `NCP_DATA_PORT_B, `NCP_DATA_PORT_C};
	endproperty
	property p_pulse;
		cp_wr |=> !cp_wr;
	endproperty
	property p_busy;
		!$past(cp_busy_n, 3) |-> !cpu_busy_n;
	endproperty
	property p_latch;
		s_fault ##1 s_quiet |-> !cpu_busy_n;
	endproperty
	property p_clear;
		s_clear ##1 (cp_busy_n && cp_error_n) [*3] |-> cpu_busy_n;
	endproperty
	property p_reset;
		$rose(cp_reset) |-> ($past(io_addr, 3) == `NCP_RESET_TRIGGER
			&& $past(io_byte, 3)) ##1 cp_reset [*8];
	endproperty
	a_board: assert property (p_board) else $error("board select bad");
	a_chan: assert property (p_chan) else $error("channel select bad");
	a_ports: assert property (p_ports) else $error("port decode bad");
	a_pulse: assert property (p_pulse) else $error("write pulse long");
	a_busy: assert property (p_busy) else $error("busy not passed");
	a_latch: assert property (p_latch) else $error("busy not held");
	a_clear: assert property (p_clear) else $error("busy not cleared");
	a_reset: assert property (p_reset) else $error("reset pulse bad");
endmodule : ncp_io_port_assertions

bind ncp_io_port ncp_io_port_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
	u_ncp_io_port_assertions (.core_clk(core_clk), .rst(rst),
	.io_addr(io_addr), .io_wr_n(io_wr_n), .io_byte(io_byte),
	.board_sel(board_sel), .chan_sel(chan_sel), .cp_wr(cp_wr),
	.cp_busy_n(cp_busy_n), .cp_error_n(cp_error_n),
	.cpu_busy_n(cpu_busy_n), .cp_reset(cp_reset));

// ===== verif/ncp_io_port_tb_top.sv
// Self-checking bench for the coprocessor I/O port.
// Drives the host strobes and commands the coprocessor model.
`timescale 1ns/1ps
`include "ncp_regs.svh"
module ncp_io_port_tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] io_addr = 10'h000;
	logic [7:0] io_wdata = 8'h00;
	logic io_wr_n = 1'b1;
	logic io_rd_n = 1'b1;
	logic io_byte = 1'b1;
	logic err_req = 1'b0;
	logic [3:0] busy_len = 4'h4;
	logic [7:0] io_rdata, cp_rdata, cp_wdata, got;
	logic oe, b_sel, c_sel, bsel, csel, cp_wr, cp_busy_n, cp_error_n;
	logic cpu_busy_n, cp_reset;
	logic cp_rd, bsy;
	logic [1:0] cp_port;
	logic [7:0] shadow [0:2];
	logic [9:0] corner [0:3] = '{10'h000, 10'h0FF, 10'h100, 10'h3FF};
	int fails = 0;
	int samples_checked = 0;
	int wrs = 0;
	int rds = 0;
	int rcyc = 0;
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		wrs <= wrs + int'(cp_wr);
		rds <= rds + int'(cp_rd);
		rcyc <= rcyc + int'(cp_reset);
	end
	ncp_io_port u_ncp_io_port (.core_clk(core_clk), .rst(rst),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_wr_n(io_wr_n),
		.io_rd_n(io_rd_n), .io_byte(io_byte), .io_rdata(io_rdata),
		.io_rdata_oe(oe), .board_sel(bsel), .chan_sel(csel),
		.cp_wr(cp_wr), .cp_rd(cp_rd), .cp_port(cp_port),
		.cp_wdata(cp_wdata),
		.cp_rdata(cp_rdata), .cp_busy_n(cp_busy_n),
		.cp_error_n(cp_error_n), .cpu_busy_n(cpu_busy_n),
		.cp_reset(cp_reset));
	ncp_cp_model u_ncp_cp_model (.core_clk(core_clk), .rst(rst),
		.cp_wr(cp_wr), .cp_port(cp_port), .cp_wdata(cp_wdata),
		.cp_reset(cp_reset), .err_req(err_req), .busy_len(busy_len),
		.cp_rdata(cp_rdata), .cp_busy_n(cp_busy_n),
		.cp_error_n(cp_error_n));
	function automatic logic [9:0] paddr(input int i);
		return i == 0 ? `NCP_DATA_PORT_A : i == 1 ? `NCP_DATA_PORT_B
			: `NCP_DATA_PORT_C;
	endfunction : paddr
	task chk(input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Strobe held 9 cycles so selects and read data have settled
	task io(input logic [9:0] a, input logic [7:0] d, input logic rd,
		input logic byt);
		@(posedge core_clk);
		io_addr <= a;
		io_wdata <= d;
		io_byte <= byt;
		io_rd_n <= !rd;
		io_wr_n <= rd;
		repeat (8) @(posedge core_clk);
		#1;
		b_sel = bsel;
		c_sel = csel;
		got = oe ? io_rdata : 8'hXX;
		bsy = cpu_busy_n;
		@(posedge core_clk);
		io_wr_n <= 1'b1;
		io_rd_n <= 1'b1;
		repeat (5) @(posedge core_clk);
	endtask : io
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
	initial begin
		logic [9:0] a;
		void'($urandom(32'hDCBB));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int n = 0; n < 16; n++) begin
			a = n < 4 ? corner[n] : 10'($urandom_range(0, 1023));
			if (a[9:4] == 6'h0F) a = 10'h080;
			io(a, 8'($urandom), 1'($urandom), 1'b1);
			chk(b_sel, a <= 10'h0FF);
			chk(c_sel, a >= 10'h100);
		end
		chk(10'(wrs + rds), 10'h000);
		for (int n = 0; n < 9; n++) begin
			busy_len <= 4'($urandom_range(3, 12));
			shadow[n % 3] = 8'($urandom);
			io(paddr(n % 3), shadow[n % 3], 1'b0, 1'b1);
			chk(bsy, 10'h000);
		end
		chk(10'(wrs), 10'h009);
		for (int n = 0; n < 3; n++) begin
			io(paddr(n), 8'h00, 1'b1, 1'b1);
			chk(got, shadow[n]);
			chk(oe, 10'h000);
		end
		chk(10'(rds), 10'h003);
		chk(cpu_busy_n, 10'h001);
		err_req <= 1'b1;
		busy_len <= 4'hF;
		io(`NCP_DATA_PORT_B, 8'h5A, 1'b0, 1'b1);
		err_req <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk({cp_busy_n, cpu_busy_n}, 10'h002);
		io(`NCP_BUSY_CLEAR, 8'hA5, 1'b0, 1'b0);
		chk(cpu_busy_n, 10'h000);
		io(`NCP_BUSY_CLEAR, 8'($urandom_range(1, 255)), 1'b0, 1'b1);
		chk(cpu_busy_n, 10'h001);
		io(`NCP_RESET_TRIGGER, 8'h00, 1'b0, 1'b0);
		chk(cp_reset, 10'h000);
		io(`NCP_RESET_TRIGGER, 8'($urandom_range(1, 255)), 1'b0, 1'b1);
		chk(cp_reset, 10'h001);
		repeat (15) @(posedge core_clk);
		chk(10'(rcyc), 10'(`NCP_RESET_PULSE_NS / `NCP_CLK_PERIOD_NS));
		give_verdict();
	end
endmodule : ncp_io_port_tb_top

// ===== verilog/ncp_busy_latch.sv
// Holds the coprocessor busy indication once the coprocessor reports error.
// Inputs come synchronised from the port decoder on the same clock.
`timescale 1ns/1ps
module ncp_busy_latch (
	input wire logic core_clk,
	input wire logic rst,
	ncp_busy_if.latch bif
);
	logic latched_reg;
	logic latched_next;

	// Setting wins over a clear in the same cycle so no error is lost
	always_comb begin
		latched_next = latched_reg;
		if (bif.clear)
			latched_next = 1'b0;
		if (bif.error && bif.busy)
			latched_next = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			latched_reg <= 1'b0;
		else
			latched_reg <= latched_next;
	end

	assign bif.latched = latched_reg;
endmodule : ncp_busy_latch

// ===== verilog/ncp_io_port.sv
// System-board I/O decode and coprocessor port logic.
// Host strobes, address, data and coprocessor pins are asynchronous
// and are synchronised here before use.
// How it works
// - Addresses 000-0FF stay on the system board
// - Addresses 100-3FF go to the expansion channel
// - Coprocessor answers at ports 0F8, 0FA, 0FC
// - Busy toward host held until coprocessor finishes
// - Error latches busy past coprocessor busy drop
// - Byte write to F0 clears latched busy
// - Byte write to F1 resets coprocessor
`timescale 1ns/1ps
`include "ncp_regs.svh"
module ncp_io_port #(
	parameter int ADDR_W = `NCP_ADDR_W,
	parameter int DATA_W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] io_addr,
	input wire logic [DATA_W-1:0] io_wdata,
	input wire logic io_wr_n,
	input wire logic io_rd_n,
	input wire logic io_byte,
	output logic [DATA_W-1:0] io_rdata,
	output logic io_rdata_oe,
	output logic board_sel,
	output logic chan_sel,
	output logic cp_wr,
	output logic cp_rd,
	output logic [1:0] cp_port,
	output logic [DATA_W-1:0] cp_wdata,
	input wire logic [DATA_W-1:0] cp_rdata,
	input wire logic cp_busy_n,
	input wire logic cp_error_n,
	output logic cpu_busy_n,
	output logic cp_reset
);
	localparam int RST_CYC_RAW =
		(`NCP_RESET_PULSE_NS + `NCP_CLK_PERIOD_NS - 1) / `NCP_CLK_PERIOD_NS;
	localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
	localparam int CNT_W = $clog2(RST_CYC + 1);

	// Two-stage synchronisers for every pin input
	logic [ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
	logic [DATA_W-1:0] wdata_s1_reg, wdata_s2_reg;
	logic [DATA_W-1:0] rdata_s1_reg, rdata_s2_reg;
	logic [4:0] ctl_s1_reg, ctl_s2_reg;
	logic wr_prev_reg, rd_prev_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_s1_reg <= '0;
			addr_s2_reg <= '0;
			wdata_s1_reg <= '0;
			wdata_s2_reg <= '0;
			rdata_s1_reg <= '0;
			rdata_s2_reg <= '0;
			ctl_s1_reg <= 5'h00;
			ctl_s2_reg <= 5'h00;
			wr_prev_reg <= 1'b0;
			rd_prev_reg <= 1'b0;
		end else begin
			addr_s1_reg <= io_addr;
			addr_s2_reg <= addr_s1_reg;
			wdata_s1_reg <= io_wdata;
			wdata_s2_reg <= wdata_s1_reg;
			rdata_s1_reg <= cp_rdata;
			rdata_s2_reg <= rdata_s1_reg;
			ctl_s1_reg <= {~io_wr_n, ~io_rd_n, io_byte, ~cp_busy_n,
				~cp_error_n};
			ctl_s2_reg <= ctl_s1_reg;
			wr_prev_reg <= ctl_s2_reg[4];
			rd_prev_reg <= ctl_s2_reg[3];
		end
	end

	logic wr_act, rd_act, byte_s, busy_s, error_s;
	assign wr_act = ctl_s2_reg[4];
	assign rd_act = ctl_s2_reg[3];
	assign byte_s = ctl_s2_reg[2];
	assign busy_s = ctl_s2_reg[1];
	assign error_s = ctl_s2_reg[0];

	// Address decode on the synchronised address
	logic on_board, on_chan, is_cp, is_clr, is_rst;
	logic [1:0] port_idx;
	always_comb begin
		on_board = (addr_s2_reg <= `NCP_BOARD_HI);
		on_chan = (addr_s2_reg >= `NCP_CHAN_LO) &&
			(addr_s2_reg <= `NCP_CHAN_HI);
		is_clr = (addr_s2_reg == `NCP_BUSY_CLEAR);
		is_rst = (addr_s2_reg == `NCP_RESET_TRIGGER);
		is_cp = 1'b1;
		port_idx = `NCP_PORT_A_IDX;
		case (addr_s2_reg)
			`NCP_DATA_PORT_A: port_idx = `NCP_PORT_A_IDX;
			`NCP_DATA_PORT_B: port_idx = `NCP_PORT_B_IDX;
			`NCP_DATA_PORT_C: port_idx = `NCP_PORT_C_IDX;
			default: is_cp = 1'b0;
		endcase
	end

	// Strobe start edges; one access per host strobe
	logic wr_start, rd_start;
	ncp_pkg::ncp_acc_t acc;
	always_comb begin
		wr_start = wr_act && !wr_prev_reg;
		rd_start = rd_act && !rd_prev_reg;
		if (wr_start)
			acc = ncp_pkg::NCP_ACC_WRITE;
		else if (rd_start)
			acc = ncp_pkg::NCP_ACC_READ;
		else
			acc = ncp_pkg::NCP_ACC_NONE;
	end

	// Coprocessor data path and host-facing decode
	logic board_sel_reg, board_sel_next;
	logic chan_sel_reg, chan_sel_next;
	logic cp_wr_reg, cp_wr_next;
	logic cp_rd_reg, cp_rd_next;
	logic [1:0] cp_port_reg, cp_port_next;
	logic [DATA_W-1:0] cp_wdata_reg, cp_wdata_next;
	logic [DATA_W-1:0] io_rdata_reg, io_rdata_next;
	logic io_rdata_oe_reg, io_rdata_oe_next;
	logic rd_cp_reg, rd_cp_next;
	logic clr_req;

	always_comb begin
		board_sel_next = (wr_act || rd_act) && on_board;
		chan_sel_next = (wr_act || rd_act) && on_chan;
		cp_wr_next = 1'b0;
		cp_rd_next = 1'b0;
		cp_port_next = cp_port_reg;
		cp_wdata_next = cp_wdata_reg;
		rd_cp_next = rd_cp_reg && rd_act;
		clr_req = 1'b0;
		case (acc)
			ncp_pkg::NCP_ACC_WRITE: begin
				if (is_cp) begin
					cp_wr_next = 1'b1;
					cp_port_next = port_idx;
					cp_wdata_next = wdata_s2_reg;
				end
				// Data bits are not looked at here
				clr_req = is_clr && byte_s;
			end
			ncp_pkg::NCP_ACC_READ: begin
				if (is_cp) begin
					cp_rd_next = 1'b1;
					cp_port_next = port_idx;
					rd_cp_next = 1'b1;
				end
			end
			default: ;
		endcase
		// Result is driven for as long as the host holds its read strobe
		io_rdata_oe_next = rd_cp_next;
		io_rdata_next = rd_cp_next ? rdata_s2_reg : `NCP_DATA_RESET;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			board_sel_reg <= 1'b0;
			chan_sel_reg <= 1'b0;
			cp_wr_reg <= 1'b0;
			cp_rd_reg <= 1'b0;
			cp_port_reg <= `NCP_PORT_A_IDX;
			cp_wdata_reg <= `NCP_DATA_RESET;
			io_rdata_reg <= `NCP_DATA_RESET;
			io_rdata_oe_reg <= 1'b0;
			rd_cp_reg <= 1'b0;
		end else begin
			board_sel_reg <= board_sel_next;
			chan_sel_reg <= chan_sel_next;
			cp_wr_reg <= cp_wr_next;
			cp_rd_reg <= cp_rd_next;
			cp_port_reg <= cp_port_next;
			cp_wdata_reg <= cp_wdata_next;
			io_rdata_reg <= io_rdata_next;
			io_rdata_oe_reg <= io_rdata_oe_next;
			rd_cp_reg <= rd_cp_next;
		end
	end

	// Coprocessor reset pulse; a new trigger during a pulse restarts it
	ncp_pkg::ncp_rst_state_t rst_state_reg, rst_state_next;
	logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
	logic cp_reset_reg, cp_reset_next;
	logic rst_req;

	always_comb begin
		rst_req = (acc == ncp_pkg::NCP_ACC_WRITE) && is_rst && byte_s;
		rst_state_next = rst_state_reg;
		rst_cnt_next = rst_cnt_reg;
		cp_reset_next = 1'b0;
		case (rst_state_reg)
			ncp_pkg::NCP_RST_IDLE: begin
				if (rst_req) begin
					rst_state_next = ncp_pkg::NCP_RST_PULSE;
					rst_cnt_next = CNT_W'(RST_CYC - 1);
					cp_reset_next = 1'b1;
				end
			end
			ncp_pkg::NCP_RST_PULSE: begin
				cp_reset_next = 1'b1;
				if (rst_req)
					rst_cnt_next = CNT_W'(RST_CYC - 1);
				else if (rst_cnt_reg == '0) begin
					rst_state_next = ncp_pkg::NCP_RST_IDLE;
					cp_reset_next = 1'b0;
				end else
					rst_cnt_next = rst_cnt_reg - 1'b1;
			end
			default: begin
				rst_state_next = ncp_pkg::NCP_RST_IDLE;
				rst_cnt_next = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_state_reg <= ncp_pkg::NCP_RST_IDLE;
			rst_cnt_reg <= '0;
			cp_reset_reg <= 1'b0;
		end else begin
			rst_state_reg <= rst_state_next;
			rst_cnt_reg <= rst_cnt_next;
			cp_reset_reg <= cp_reset_next;
		end
	end

	// Busy toward the host: live busy or the error-latched copy
	ncp_busy_if bif ();
	assign bif.busy = busy_s;
	assign bif.error = error_s;
	assign bif.clear = clr_req;

	ncp_busy_latch u_latch (
		.core_clk(core_clk),
		.rst(rst),
		.bif(bif)
	);

	logic cpu_busy_n_reg, cpu_busy_n_next;
	always_comb begin
		cpu_busy_n_next = !(busy_s || bif.latched);
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			cpu_busy_n_reg <= `NCP_SYNC_RESET;
		else
			cpu_busy_n_reg <= cpu_busy_n_next;
	end

	assign io_rdata = io_rdata_reg;
	assign io_rdata_oe = io_rdata_oe_reg;
	assign board_sel = board_sel_reg;
	assign chan_sel = chan_sel_reg;
	assign cp_wr = cp_wr_reg;
	assign cp_rd = cp_rd_reg;
	assign cp_port = cp_port_reg;
	assign cp_wdata = cp_wdata_reg;
	assign cpu_busy_n = cpu_busy_n_reg;
	assign cp_reset = cp_reset_reg;
endmodule : ncp_io_port
